// ==== inc/mcr_defines.vh ====
// Constants for the monitor configuration and result block
`ifndef MCR_DEFINES_VH
`define MCR_DEFINES_VH

`define MCR_REG_CFG 8'h00
`define MCR_REG_SHUNT1 8'h01
`define MCR_REG_BUS1 8'h02
`define MCR_CFG_RESET 16'h7127
`define MCR_RES_RESET 16'h0000
`define MCR_RD_UNMAPPED 16'h0000
`define MCR_CFG_RST_BIT 15
`define MCR_CFG_EN_HI 14
`define MCR_CFG_EN_LO 12
`define MCR_CFG_AVG_HI 11
`define MCR_CFG_AVG_LO 9
`define MCR_CFG_BCT_HI 8
`define MCR_CFG_BCT_LO 6
`define MCR_CFG_SCT_HI 5
`define MCR_CFG_SCT_LO 3
`define MCR_CFG_MODE_HI 2
`define MCR_CFG_MODE_LO 0
`define MCR_MODE_SHUNT_BIT 0
`define MCR_MODE_BUS_BIT 1
`define MCR_MODE_CONT_BIT 2
`define MCR_RES_PAD 3'h0
`define MCR_I2C_ADDR 7'h40
`define MCR_BYTE_BITS 4'h8

`define MCR_CLK_MHZ 250
`define MCR_CT0_NS 140000
`define MCR_CT1_NS 204000
`define MCR_CT2_NS 332000
`define MCR_CT3_NS 588000
`define MCR_CT4_NS 1100000
`define MCR_CT5_NS 2116000
`define MCR_CT6_NS 4156000
`define MCR_CT7_NS 8244000
`define MCR_NS_PER_US 1000

`define MCR_AVG_SH0 4'h0
`define MCR_AVG_SH1 4'h2
`define MCR_AVG_SH2 4'h4
`define MCR_AVG_SH3 4'h6
`define MCR_AVG_SH4 4'h7
`define MCR_AVG_SH5 4'h8
`define MCR_AVG_SH6 4'h9
`define MCR_AVG_SH7 4'hA

`define MCR_SLOT_FIRST 3'h0
`define MCR_SLOT_LAST 5
`define MCR_CNT_ONE 24'h000001
`define MCR_SMP_ONE 11'h001

`endif

// ==== logic/mcr_avg.v ====
// Sample accumulator producing one averaged result per slot
`timescale 1ns/1ps
`default_nettype none
`include "mcr_defines.vh"
module mcr_avg (
   input wire clk_i,
   input wire rst_n_i,
   input wire clr_i,
   input wire smp_i,
   input wire last_i,
   input wire [3:0] shift_i,
   input wire [12:0] data_i,
   input wire [2:0] tag_i,
   output reg valid_o,
   output reg [12:0] res_o,
   output reg [2:0] tag_o
);
   reg [22:0] acc_q;
   wire signed [22:0] sum_w;
   wire signed [22:0] avg_w;

   assign sum_w = $signed(acc_q) + $signed({{10{data_i[12]}}, data_i});
   // Arithmetic shift keeps the sign of negative averages
   assign avg_w = sum_w >>> shift_i;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= 23'h000000;
         valid_o <= 1'b0;
         res_o <= 13'h0000;
         tag_o <= 3'h0;
      end else begin
         valid_o <= 1'b0;
         // Aborted averages must not leak into the next pass
         if (clr_i) begin
            acc_q <= 23'h000000;
         end else if (smp_i) begin
            if (last_i) begin
               acc_q <= 23'h000000;
               res_o <= avg_w[12:0];
               tag_o <= tag_i;
               valid_o <= 1'b1;
            end else begin
               acc_q <= sum_w;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== logic/mcr_seq.v ====
// Conversion sequencer walking enabled channel and quantity slots
`timescale 1ns/1ps
`default_nettype none
`include "mcr_defines.vh"
module mcr_seq (
   input wire clk_i,
   input wire rst_n_i,
   input wire restart_i,
   input wire hold_i,
   input wire [2:0] en_i,
   input wire [2:0] mode_i,
   input wire [23:0] shunt_cyc_i,
   input wire [23:0] bus_cyc_i,
   input wire [3:0] shift_i,
   output reg busy_o,
   output reg [2:0] slot_o,
   output reg strobe_o,
   output reg last_o,
   output reg [2:0] tag_o
);
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   reg [23:0] cnt_q;
   reg [10:0] smp_q;
   reg [3:0] nx_d;
   wire [10:0] n_m1;
   wire [3:0] first_w;

   // Slot = channel * 2 + quantity; lowest enabled slot at or after from
   function [3:0] find_slot;
      input [2:0] from;
      input [2:0] en;
      input [2:0] mode;
      integer i;
      reg [3:0] r;
      begin
         r = 4'h0;
         for (i = `MCR_SLOT_LAST; i >= 0; i = i - 1) begin
            if (i >= from && en[2 - i / 2] && mode[i % 2]) begin
               r = {1'b1, i[2:0]};
            end
         end
         find_slot = r;
      end
   endfunction

   function [23:0] slot_cyc;
      input [2:0] slot;
      begin
         slot_cyc = slot[0] ? bus_cyc_i : shunt_cyc_i;
      end
   endfunction

   assign n_m1 = (`MCR_SMP_ONE << shift_i) - `MCR_SMP_ONE;
   assign first_w = find_slot(`MCR_SLOT_FIRST, en_i, mode_i);

   always @* begin
      nx_d = find_slot(slot_o + 3'h1, en_i, mode_i);
      if (!nx_d[3] && mode_i[`MCR_MODE_CONT_BIT]) begin
         nx_d = find_slot(`MCR_SLOT_FIRST, en_i, mode_i);
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= ST_IDLE;
         slot_o <= 3'h0;
         strobe_o <= 1'b0;
         last_o <= 1'b0;
         tag_o <= 3'h0;
         cnt_q <= 24'h000000;
         smp_q <= 11'h000;
      end else begin
         strobe_o <= 1'b0;
         last_o <= 1'b0;
         if (restart_i) begin
            smp_q <= 11'h000;
            if (first_w[3]) begin
               busy_o <= ST_CONV;
               slot_o <= first_w[2:0];
               cnt_q <= slot_cyc(first_w[2:0]);
            end else begin
               busy_o <= ST_IDLE;
            end
         end else begin
            case (busy_o)
               ST_CONV: begin
                  // Counter freezes while a configuration write is open
                  if (!hold_i) begin
                     if (cnt_q == `MCR_CNT_ONE) begin
                        strobe_o <= 1'b1;
                        tag_o <= slot_o;
                        last_o <= (smp_q == n_m1);
                        if (smp_q != n_m1) begin
                           smp_q <= smp_q + `MCR_SMP_ONE;
                           cnt_q <= slot_cyc(slot_o);
                        end else begin
                           smp_q <= 11'h000;
                           if (nx_d[3]) begin
                              slot_o <= nx_d[2:0];
                              cnt_q <= slot_cyc(nx_d[2:0]);
                           end else begin
                              busy_o <= ST_IDLE;
                           end
                        end
                     end else begin
                        cnt_q <= cnt_q - `MCR_CNT_ONE;
                     end
                  end
               end
               default: begin
                  busy_o <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== logic/mcr_top.v ====
// Two-wire register slave, configuration and channel-one results
`timescale 1ns/1ps
`default_nettype none
`include "mcr_defines.vh"
module mcr_top #(
   parameter [23:0] CT0_CYC = `MCR_CT0_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT1_CYC = `MCR_CT1_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT2_CYC = `MCR_CT2_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT3_CYC = `MCR_CT3_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT4_CYC = `MCR_CT4_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT5_CYC = `MCR_CT5_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT6_CYC = `MCR_CT6_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [23:0] CT7_CYC = `MCR_CT7_NS * `MCR_CLK_MHZ / `MCR_NS_PER_US,
   parameter [6:0] DEV_ADDR = `MCR_I2C_ADDR
) (
   input wire MCLK_I,
   input wire RSTN_I,
   input wire SCL_I,
   input wire SDA_I,
   input wire [12:0] SAMPLE_I,
   output reg SDA_O,
   output reg SDA_OE_O,
   output reg ADC_RUN_O,
   output reg [1:0] ADC_CHAN_O,
   output reg ADC_BUS_O
);
   localparam ST_IDLE = 4'h0;
   localparam ST_ADDR = 4'h1;
   localparam ST_ADDR_ACK = 4'h2;
   localparam ST_PTR = 4'h3;
   localparam ST_PTR_ACK = 4'h4;
   localparam ST_WDATA = 4'h5;
   localparam ST_WDATA_ACK = 4'h6;
   localparam ST_RDATA = 4'h7;
   localparam ST_RD_ACK = 4'h8;

   reg rst_s1_q;
   reg rst_s2_q;
   reg scl_s1_q;
   reg scl_s2_q;
   reg scl_s3_q;
   reg sda_s1_q;
   reg sda_s2_q;
   reg sda_s3_q;
   reg [15:0] cfg_q;
   reg [15:0] shunt1_q;
   reg [15:0] bus1_q;
   reg [7:0] ptr_q;
   reg [3:0] st_q;
   reg [7:0] sr_q;
   reg [3:0] cnt_q;
   reg rw_q;
   reg byte_q;
   reg [7:0] hi_q;
   reg [15:0] tx_q;
   reg nack_q;
   reg hold_q;
   reg cfg_wr_q;
   reg restart_q;
   reg soft_q;
   reg [15:0] rd_word;
   wire rst_n;
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire [15:0] wr_word;
   wire seq_busy;
   wire [2:0] seq_slot;
   wire seq_strobe;
   wire seq_last;
   wire [2:0] seq_tag;
   wire avg_valid;
   wire [12:0] avg_res;
   wire [2:0] avg_tag;
   wire [3:0] avg_shift;

   function [23:0] ct_cycles;
      input [2:0] code;
      begin
         case (code)
            3'h0: ct_cycles = CT0_CYC;
            3'h1: ct_cycles = CT1_CYC;
            3'h2: ct_cycles = CT2_CYC;
            3'h3: ct_cycles = CT3_CYC;
            3'h4: ct_cycles = CT4_CYC;
            3'h5: ct_cycles = CT5_CYC;
            3'h6: ct_cycles = CT6_CYC;
            default: ct_cycles = CT7_CYC;
         endcase
      end
   endfunction

   function [3:0] avg_sh;
      input [2:0] code;
      begin
         case (code)
            3'h0: avg_sh = `MCR_AVG_SH0;
            3'h1: avg_sh = `MCR_AVG_SH1;
            3'h2: avg_sh = `MCR_AVG_SH2;
            3'h3: avg_sh = `MCR_AVG_SH3;
            3'h4: avg_sh = `MCR_AVG_SH4;
            3'h5: avg_sh = `MCR_AVG_SH5;
            3'h6: avg_sh = `MCR_AVG_SH6;
            default: avg_sh = `MCR_AVG_SH7;
         endcase
      end
   endfunction

   assign rst_n = rst_s2_q;
   // Edges come from synchronised copies only, never the first stage
   assign scl_rise = scl_s2_q & ~scl_s3_q;
   assign scl_fall = ~scl_s2_q & scl_s3_q;
   assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
   assign wr_word = {hi_q, sr_q};
   assign avg_shift = avg_sh(cfg_q[`MCR_CFG_AVG_HI:`MCR_CFG_AVG_LO]);

   // Read mux is side-effect free, so reads never touch conversions
   always @* begin
      case (ptr_q)
         `MCR_REG_CFG: rd_word = cfg_q;
         `MCR_REG_SHUNT1: rd_word = shunt1_q;
         `MCR_REG_BUS1: rd_word = bus1_q;
         default: rd_word = `MCR_RD_UNMAPPED;
      endcase
   end

   always @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   mcr_seq u_seq (
      .clk_i(MCLK_I),
      .rst_n_i(rst_n),
      .restart_i(restart_q),
      .hold_i(hold_q),
      .en_i(cfg_q[`MCR_CFG_EN_HI:`MCR_CFG_EN_LO]),
      .mode_i(cfg_q[`MCR_CFG_MODE_HI:`MCR_CFG_MODE_LO]),
      .shunt_cyc_i(ct_cycles(cfg_q[`MCR_CFG_SCT_HI:`MCR_CFG_SCT_LO])),
      .bus_cyc_i(ct_cycles(cfg_q[`MCR_CFG_BCT_HI:`MCR_CFG_BCT_LO])),
      .shift_i(avg_shift),
      .busy_o(seq_busy),
      .slot_o(seq_slot),
      .strobe_o(seq_strobe),
      .last_o(seq_last),
      .tag_o(seq_tag)
   );

   mcr_avg u_avg (
      .clk_i(MCLK_I),
      .rst_n_i(rst_n),
      .clr_i(restart_q),
      .smp_i(seq_strobe),
      .last_i(seq_last),
      .shift_i(avg_shift),
      .data_i(SAMPLE_I),
      .tag_i(seq_tag),
      .valid_o(avg_valid),
      .res_o(avg_res),
      .tag_o(avg_tag)
   );

   always @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
         cfg_q <= `MCR_CFG_RESET;
         shunt1_q <= `MCR_RES_RESET;
         bus1_q <= `MCR_RES_RESET;
         ptr_q <= `MCR_REG_CFG;
         st_q <= ST_IDLE;
         sr_q <= 8'h00;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         byte_q <= 1'b0;
         hi_q <= 8'h00;
         tx_q <= 16'h0000;
         nack_q <= 1'b0;
         hold_q <= 1'b0;
         cfg_wr_q <= 1'b0;
         restart_q <= 1'b1;
         soft_q <= 1'b0;
         SDA_O <= 1'b0;
         SDA_OE_O <= 1'b0;
         ADC_RUN_O <= 1'b0;
         ADC_CHAN_O <= 2'h0;
         ADC_BUS_O <= 1'b0;
      end else begin
         scl_s1_q <= SCL_I;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= SDA_I;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
         SDA_O <= 1'b0;
         ADC_RUN_O <= seq_busy;
         ADC_CHAN_O <= seq_slot[2:1];
         ADC_BUS_O <= seq_slot[0];
         restart_q <= soft_q;
         soft_q <= 1'b0;
         // Only the channel-one slots own result registers here
         if (avg_valid && avg_tag[2:1] == 2'h0) begin
            if (avg_tag[0]) begin
               bus1_q <= {avg_res, `MCR_RES_PAD};
            end else begin
               shunt1_q <= {avg_res, `MCR_RES_PAD};
            end
         end
         if (bus_start || bus_stop) begin
            if (cfg_wr_q) begin
               restart_q <= 1'b1;
               cfg_wr_q <= 1'b0;
            end
            hold_q <= 1'b0;
            SDA_OE_O <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= bus_start ? ST_ADDR : ST_IDLE;
         end else if (scl_rise) begin
            case (st_q)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  sr_q <= {sr_q[6:0], sda_s2_q};
                  cnt_q <= cnt_q + 4'h1;
               end
               ST_RD_ACK: begin
                  nack_q <= sda_s2_q;
               end
               default: begin
                  nack_q <= nack_q;
               end
            endcase
         end else if (scl_fall) begin
            case (st_q)
               ST_ADDR: begin
                  if (cnt_q == `MCR_BYTE_BITS) begin
                     if (sr_q[7:1] == DEV_ADDR) begin
                        SDA_OE_O <= 1'b1;
                        rw_q <= sr_q[0];
                        st_q <= ST_ADDR_ACK;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     // Whole word is captured so both bytes belong together
                     tx_q <= {rd_word[14:0], 1'b0};
                     SDA_OE_O <= ~rd_word[15];
                     cnt_q <= 4'h1;
                     byte_q <= 1'b0;
                     st_q <= ST_RDATA;
                  end else begin
                     SDA_OE_O <= 1'b0;
                     st_q <= ST_PTR;
                  end
               end
               ST_PTR: begin
                  if (cnt_q == `MCR_BYTE_BITS) begin
                     ptr_q <= sr_q;
                     SDA_OE_O <= 1'b1;
                     st_q <= ST_PTR_ACK;
                  end
               end
               ST_PTR_ACK: begin
                  SDA_OE_O <= 1'b0;
                  cnt_q <= 4'h0;
                  byte_q <= 1'b0;
                  st_q <= ST_WDATA;
                  if (ptr_q == `MCR_REG_CFG) begin
                     hold_q <= 1'b1;
                  end
               end
               ST_WDATA: begin
                  if (cnt_q == `MCR_BYTE_BITS) begin
                     SDA_OE_O <= 1'b1;
                     st_q <= ST_WDATA_ACK;
                     if (!byte_q) begin
                        hi_q <= sr_q;
                     end else if (ptr_q == `MCR_REG_CFG) begin
                        if (wr_word[`MCR_CFG_RST_BIT]) begin
                           // Full reset; stored bit reads back as zero
                           cfg_q <= `MCR_CFG_RESET;
                           shunt1_q <= `MCR_RES_RESET;
                           bus1_q <= `MCR_RES_RESET;
                           ptr_q <= `MCR_REG_CFG;
                           soft_q <= 1'b1;
                        end else begin
                           cfg_q <= wr_word;
                           cfg_wr_q <= 1'b1;
                        end
                     end
                  end
               end
               ST_WDATA_ACK: begin
                  SDA_OE_O <= 1'b0;
                  cnt_q <= 4'h0;
                  byte_q <= ~byte_q;
                  st_q <= ST_WDATA;
               end
               ST_RDATA: begin
                  if (cnt_q == `MCR_BYTE_BITS) begin
                     SDA_OE_O <= 1'b0;
                     st_q <= ST_RD_ACK;
                  end else begin
                     SDA_OE_O <= ~tx_q[15];
                     tx_q <= {tx_q[14:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               ST_RD_ACK: begin
                  if (nack_q) begin
                     st_q <= ST_IDLE;
                  end else begin
                     cnt_q <= 4'h1;
                     st_q <= ST_RDATA;
                     if (byte_q) begin
                        tx_q <= {rd_word[14:0], 1'b0};
                        SDA_OE_O <= ~rd_word[15];
                        byte_q <= 1'b0;
                     end else begin
                        SDA_OE_O <= ~tx_q[15];
                        tx_q <= {tx_q[14:0], 1'b0};
                        byte_q <= 1'b1;
                     end
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/mcr_top_sva.sv ====
// Port checker for the monitor configuration and result block
`timescale 1ns/1ps
`default_nettype none
module mcr_top_sva (
   input wire MCLK_I,
   input wire RSTN_I,
   input wire SCL_I,
   input wire SDA_I,
   input wire [12:0] SAMPLE_I,
   input wire SDA_O,
   input wire SDA_OE_O,
   input wire ADC_RUN_O,
   input wire [1:0] ADC_CHAN_O,
   input wire ADC_BUS_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   property p_sda_zero;
      SDA_O == 1'b0;
   endproperty
   a_sda_zero: assert property (p_sda_zero)
      else $error("data pin driven high");
   property p_run_rst;
      $rose(RSTN_I) |-> ##[2:10] ADC_RUN_O;
   endproperty
   a_run_rst: assert property (p_run_rst)
      else $error("no conversion after reset");
   // Default enables and mode start on channel one shunt
   property p_first_slot;
      $rose(RSTN_I) |-> ##[2:10] (ADC_RUN_O && ADC_CHAN_O == 2'h0 && !ADC_BUS_O);
   endproperty
   a_first_slot: assert property (p_first_slot)
      else $error("wrong first slot");
   property p_chan_range;
      ADC_RUN_O |-> ADC_CHAN_O != 2'h3;
   endproperty
   a_chan_range: assert property (p_chan_range)
      else $error("channel out of range");
   // Data may only move while the clock pin is low
   property p_oe_scl_low;
      $changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2);
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data moved with clock high");
   property p_oe_lag;
      $fell(SCL_I) |-> $stable(SDA_OE_O) [*2];
   endproperty
   a_oe_lag: assert property (p_oe_lag)
      else $error("data moved too soon after clock fall");
   property p_start_quiet;
      $fell(SDA_I) && SCL_I |-> !SDA_OE_O [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet)
      else $error("pin driven after start");
   property p_stop_quiet;
      $rose(SDA_I) && SCL_I |=> !SDA_OE_O [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("pin driven after stop");
   c_ack: cover property ($rose(SDA_OE_O));
   c_idle: cover property ($fell(ADC_RUN_O));
   c_bus: cover property (ADC_RUN_O && ADC_BUS_O);
endmodule
bind mcr_top mcr_top_sva i_sva (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
   .SCL_I(SCL_I), .SDA_I(SDA_I), .SAMPLE_I(SAMPLE_I), .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O), .ADC_RUN_O(ADC_RUN_O), .ADC_CHAN_O(ADC_CHAN_O),
   .ADC_BUS_O(ADC_BUS_O));
`default_nettype wire

// ==== verif/mcr_host.sv ====
// Two-wire bus host model driving clock and data pins
`timescale 1ns/1ps
`default_nettype none
module mcr_host (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   logic last_ack;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      last_ack = 1'b1;
   end
   task wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Data moves mid low phase, so setup and hold both get 4 cycles
   task bit_x(input logic b, output logic r);
      wt(4);
      sda_o <= b;
      wt(4);
      scl_o <= 1'b1;
      wt(7);
      r = sda_i;
      wt(1);
      scl_o <= 1'b0;
   endtask
   task start;
      wt(4);
      sda_o <= 1'b1;
      wt(4);
      scl_o <= 1'b1;
      wt(8);
      sda_o <= 1'b0;
      wt(8);
      scl_o <= 1'b0;
   endtask
   // Clock stays high between frames
   task stop;
      wt(4);
      sda_o <= 1'b0;
      wt(4);
      scl_o <= 1'b1;
      wt(8);
      sda_o <= 1'b1;
      wt(8);
   endtask
   task byte_x(input logic [7:0] d, input logic a, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(a, last_ack);
   endtask
endmodule
`default_nettype wire

// ==== verif/mcr_top_test.sv ====
// Self-checking bench for the monitor configuration block
`timescale 1ns/1ps
`default_nettype none
`include "mcr_defines.vh"
module mcr_top_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic clr = 1'b0;
   logic [12:0] smp = 13'h0000;
   logic [12:0] sh_v = 13'h0000;
   logic [12:0] bus_v = 13'h0000;
   logic [31:0] seed = 32'h72C47BC6;
   logic [3:0] saw = 4'h0;
   logic [3:0] ex;
   logic [2:0] m;
   logic [15:0] cf;
   logic [15:0] exp_q[$];
   logic [15:0] got_w;
   event got_e;
   int fails = 0;
   int cmp_count = 0;
   localparam logic [23:0] ct0_cyc = 24'h00001E;
   localparam logic [23:0] ct1_cyc = 24'h000022;
   localparam logic [23:0] ct4_cyc = 24'h000FA0;
   logic [15:0] runs = 16'h0000;
   logic run_d = 1'b0;
   wire scl;
   wire sda_h;
   wire sda_w;
   wire oe;
   wire run;
   wire bus;
   wire [1:0] chan;
   always #2 clk = ~clk;
   // Pulled-up wire: low while either side pulls
   assign sda_w = sda_h & ~oe;
   mcr_host i_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
   // Only the time codes that scenarios select are shortened
   mcr_top #(.CT0_CYC(ct0_cyc), .CT1_CYC(ct1_cyc), .CT4_CYC(ct4_cyc))
      i_dut (.MCLK_I(clk),
      .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda_w), .SAMPLE_I(smp),
      .SDA_O(), .SDA_OE_O(oe), .ADC_RUN_O(run), .ADC_CHAN_O(chan),
      .ADC_BUS_O(bus));
   // Constant sample per quantity keeps any average exact
   always @(posedge clk) begin
      smp <= bus ? bus_v : sh_v;
      run_d <= run;
      // Length of the latest conversion burst
      runs <= (run & ~run_d) ? 16'h0001 : runs + {15'h0000, run};
      if (clr) begin
         saw <= 4'h0;
      end else begin
         saw <= saw | {run & bus, run & !bus, run & (chan == 2'h0),
            run & (chan != 2'h0)};
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task ack_ok;
      chk({15'h0000, i_host.last_ack}, 16'h0000);
   endtask
   task wr(input logic [7:0] p, input logic [15:0] v, input logic n);
      logic [7:0] q;
      i_host.start;
      i_host.byte_x({`MCR_I2C_ADDR, 1'b0}, 1'b1, q);
      ack_ok;
      i_host.byte_x(p, 1'b1, q);
      ack_ok;
      if (n) begin
         i_host.byte_x(v[15:8], 1'b1, q);
         i_host.byte_x(v[7:0], 1'b1, q);
         ack_ok;
      end
      i_host.stop;
   endtask
   task rd(input logic [7:0] p, input logic [15:0] e);
      logic [7:0] hi;
      logic [7:0] lo;
      wr(p, 16'h0000, 1'b0);
      exp_q.push_back(e);
      i_host.start;
      i_host.byte_x({`MCR_I2C_ADDR, 1'b1}, 1'b1, hi);
      ack_ok;
      i_host.byte_x(8'hFF, 1'b0, hi);
      i_host.byte_x(8'hFF, 1'b1, lo);
      i_host.stop;
      got_w = {hi, lo};
      -> got_e;
   endtask
   always @(got_e) chk(got_w, exp_q.pop_front());
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (10) @(posedge clk);
      rd(8'h01, 16'h0000);
      rd(8'h02, 16'h0000);
      rd(8'h00, 16'h7127);
      rd(8'h05, 16'h0000);
      $display("reset values test done");
      repeat (9) seed = lfsr(seed);
      sh_v <= {1'b1, seed[11:0]};
      bus_v <= {1'b0, seed[27:16]};
      wr(8'h00, 16'h4207, 1'b1);
      rd(8'h00, 16'h4207);
      rd(8'h00, 16'h4207);
      repeat (600) @(posedge clk);
      rd(8'h01, {sh_v, 3'h0});
      rd(8'h02, {bus_v, 3'h0});
      $display("averaged results test done");
      for (int i = 0; i < 9; i++) begin
         cf = (i < 8) ? {13'h0800, i[2:0]} : 16'h2007;
         m = cf[2:0];
         ex = {m[1], m[0], (i < 8) && (m[1:0] != 2'h0), i == 8};
         wr(8'h00, cf, 1'b1);
         repeat (4) @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         repeat (300) @(posedge clk);
         chk({15'h0000, run}, {15'h0000, m[2] && (m[1:0] != 2'h0)});
         chk({12'h000, saw}, {12'h000, ex});
      end
      $display("mode and enable test done");
      // Power-down first so the next burst is measured from its start
      wr(8'h00, 16'h4000, 1'b1);
      wr(8'h00, 16'h4242, 1'b1);
      repeat (300) @(posedge clk);
      chk(runs, {ct1_cyc[13:0], 2'h0});
      wr(8'h00, 16'h4009, 1'b1);
      repeat (300) @(posedge clk);
      chk(runs, ct1_cyc[15:0]);
      $display("conversion time test done");
      wr(8'h00, 16'hC000, 1'b1);
      rd(8'h00, 16'h7127);
      rd(8'h01, 16'h0000);
      wr(8'h01, 16'hFFF8, 1'b1);
      rd(8'h01, 16'h0000);
      $display("soft reset test done");
      close_out;
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      close_out;
   end
endmodule
`default_nettype wire
